// *** inc/mscp_pkg.sv ***
package mscp_pkg;

  // Serial command and status framing.
  localparam int CMD_BITS      = 7;
  localparam int STAT_BITS     = 4;
  localparam int CMD_TONE_BIT  = 6;
  localparam int CMD_VAL_BIT   = 5;
  localparam int CMD_BANK_BIT  = 4;
  localparam int CNT_W         = 3;

  // Non-tone function indices, bank bit in position 4.
  localparam logic [4:0] FN_RESET      = 5'h00;
  localparam logic [4:0] FN_TONE       = 5'h01;
  localparam logic [4:0] FN_FORCE_MARK = 5'h02;
  localparam logic [4:0] FN_TX_LVL0    = 5'h03;
  localparam logic [4:0] FN_TX_LVL1    = 5'h04;
  localparam logic [4:0] FN_TX_ON      = 5'h05;
  localparam logic [4:0] FN_ALOOP      = 5'h06;
  localparam logic [4:0] FN_CPM        = 5'h07;
  localparam logic [4:0] FN_CONN       = 5'h08;
  localparam logic [4:0] FN_AUD_LVL0   = 5'h09;
  localparam logic [4:0] FN_AUD_LVL1   = 5'h0A;
  localparam logic [4:0] FN_FRAME0     = 5'h0B;
  localparam logic [4:0] FN_FRAME1     = 5'h0C;
  localparam logic [4:0] FN_SYNC       = 5'h0D;
  localparam logic [4:0] FN_SPEED      = 5'h0E;
  localparam logic [4:0] FN_ANSWER     = 5'h0F;
  localparam logic [4:0] FN_TX_SPACE   = 5'h10;
  localparam logic [4:0] FN_SCR_OFF    = 5'h11;
  localparam logic [4:0] FN_DLOOP      = 5'h12;
  localparam logic [4:0] FN_DOTTING    = 5'h13;
  localparam logic [4:0] FN_LOCKED     = 5'h14;
  localparam logic [4:0] FN_EXT_SLAVE  = 5'h15;
  localparam logic [4:0] FN_ANS_TONE   = 5'h17;

  // Tone-mode codes above the dial digits.
  localparam logic [3:0] TN_LAST_DIGIT = 4'hB;
  localparam logic [3:0] TN_GUARD_550  = 4'hC;
  localparam logic [3:0] TN_GUARD_1800 = 4'hD;
  localparam logic [3:0] TN_ROW_OFF    = 4'hE;
  localparam logic [3:0] TN_COL_OFF    = 4'hF;

  // Status bit positions.
  localparam int ST_ENERGY = 0;
  localparam int ST_FSK    = 1;
  localparam int ST_PSK    = 2;
  localparam int ST_UNSCR  = 3;

  // Bit clock timing.
  localparam int SYS_CLK_HZ   = 40_000_000;
  localparam int BIT_CLK_HZ   = 1200;
  localparam int BIT_HALF_CYC = SYS_CLK_HZ / (2 * BIT_CLK_HZ);
  localparam int DIV_W        = 16;

  typedef struct packed {
    logic       tone_on;
    logic       force_mark;
    logic [1:0] tx_level;
    logic       tx_on;
    logic       analog_loopback;
    logic       call_progress_monitor;
    logic       connect_indicator;
    logic [1:0] audio_level;
    logic [1:0] frame_length;
    logic       sync_mode;
    logic       high_speed;
    logic       answer_mode;
    logic       tx_space;
    logic       scrambler_off;
    logic       digital_loopback;
    logic       dotting_pattern_send;
    logic       locked_internal;
    logic       ext_slave;
    logic       answer_tone;
    logic       dial_on;
    logic [3:0] dial_digit;
    logic       guard_550;
    logic       guard_1800;
    logic       row_off;
    logic       col_off;
  } mscp_mode_t;

  localparam mscp_mode_t MODE_DEFAULT = '{frame_length: 2'h2, default: '0};

  typedef struct packed {
    logic sck;
    logic wr_n;
    logic rd_n;
    logic dio;
    logic txclk;
    logic txd;
    logic demod;
    logic [STAT_BITS-1:0] stat;
  } mscp_pins_t;

  typedef struct packed {
    mscp_pins_t                 sync1;
    mscp_pins_t                 sync2;
    mscp_pins_t                 prev;
    logic [CMD_BITS-1:0]        shift;
    logic [CNT_W-1:0]           shift_cnt;
    logic [STAT_BITS-1:0]       stat_shift;
    logic                       dio_out;
    logic                       dio_oe;
    mscp_mode_t                 mode;
    logic [DIV_W-1:0]           div_cnt;
    logic                       bit_clk;
    logic                       tx_clk_out;
    logic                       tx_clk_oe;
    logic                       rx_clk_out;
    logic                       rx_data;
    logic                       tx_mark;
    logic                       ans_tone_act;
  } mscp_state_t;

endpackage : mscp_pkg

// *** verilog/mscp_port.sv ***
`timescale 1ns/10ps
`default_nettype none

// Function
// - Shift command bit on clock rise, write low.
// - Latch command when write strobe rises.
// - At most seven command bits accepted.
// - Drive status bit per clock rise, read low.
// - Status read returns four bits at most.
// - D6 tone select, D5 value, D4..D0 function.
// - Function 02 forces receive data mark.
// - Functions 3,4 set transmit level bits.
// - Functions 9,A set audio attenuation bits.
// - Functions B,C set frame length, default 10.
// - Tone C/D give 550/1800 Hz guard.
// - Bank-one 7 answer tone, low speed only.
// - Bank-zero toggles of modem mode functions.
// - Bank-one toggles of test and clock modes.
// - Transmit data high is mark, low space.
// - Receive data mark high, space low.
// - Internal sync high speed drives transmit clock.
// - External sync high speed drives receive clock out.
// - Serial bits travel least significant first.
// - Status energy, FSK, PSK, unscrambled mark.
module mscp_port #(
  parameter int BIT_HALF_CYC = mscp_pkg::BIT_HALF_CYC
) (
  // System clock and reset.
  input  wire logic                           clk_sys,
  input  wire logic                           sys_rst,
  // Serial command and status port.
  input  wire logic                           sck,
  input  wire logic                           wr_n,
  input  wire logic                           rd_n,
  input  wire logic                           dio_in,
  output var  logic                           dio_out,
  output var  logic                           dio_oe,
  // Terminal data.
  input  wire logic                           tx_data_in,
  output var  logic                           tx_mark,
  input  wire logic                           demod_in,
  output var  logic                           rx_data_out,
  // Synchronous bit clocks.
  input  wire logic                           tx_bit_clock_in,
  output var  logic                           tx_bit_clock_out,
  output var  logic                           tx_bit_clock_oe,
  output var  logic                           rx_bit_clock,
  // Receiver status and mode settings.
  input  wire logic [mscp_pkg::STAT_BITS-1:0] stat_in,
  output var  mscp_pkg::mscp_mode_t           mode_out,
  output var  logic                           answer_tone_active
);
  import mscp_pkg::*;

  mscp_state_t st_ff;
  mscp_state_t nxt_st;
  mscp_pins_t  pins_in;

  // Apply one latched command to the mode settings.
  function automatic mscp_mode_t apply_cmd(input mscp_mode_t m,
                                           input logic [CMD_BITS-1:0] c);
    mscp_mode_t r;
    logic       v;
    logic [3:0] tc;
    logic [4:0] fn;
    r  = m;
    v  = c[CMD_VAL_BIT];
    tc = c[3:0];
    fn = c[CMD_BANK_BIT:0];
    if (c[CMD_TONE_BIT]) begin
      if (tc == TN_GUARD_550) begin
        r.guard_550 = v;
      end else if (tc == TN_GUARD_1800) begin
        r.guard_1800 = v;
      end else if (tc == TN_ROW_OFF) begin
        r.row_off = v;
      end else if (tc == TN_COL_OFF) begin
        r.col_off = v;
      end else begin
        r.dial_digit = tc;
        r.dial_on    = v;
      end
    end else begin
      case (fn)
        FN_RESET:      r = MODE_DEFAULT;
        FN_TONE:       r.tone_on = v;
        FN_FORCE_MARK: r.force_mark = v;
        FN_TX_LVL0:    r.tx_level[0] = v;
        FN_TX_LVL1:    r.tx_level[1] = v;
        FN_TX_ON:      r.tx_on = v;
        FN_ALOOP:      r.analog_loopback = v;
        FN_CPM:        r.call_progress_monitor = v;
        FN_CONN:       r.connect_indicator = v;
        FN_AUD_LVL0:   r.audio_level[0] = v;
        FN_AUD_LVL1:   r.audio_level[1] = v;
        FN_FRAME0:     r.frame_length[0] = v;
        FN_FRAME1:     r.frame_length[1] = v;
        FN_SYNC:       r.sync_mode = v;
        FN_SPEED:      r.high_speed = v;
        FN_ANSWER:     r.answer_mode = v;
        FN_TX_SPACE:   r.tx_space = v;
        FN_SCR_OFF:    r.scrambler_off = v;
        FN_DLOOP:      r.digital_loopback = v;
        FN_DOTTING:    r.dotting_pattern_send = v;
        FN_LOCKED:     r.locked_internal = v;
        FN_EXT_SLAVE:  r.ext_slave = v;
        FN_ANS_TONE:   r.answer_tone = v;
        // Unassigned function indices leave the settings alone.
        default:       r = m;
      endcase
    end
    return r;
  endfunction : apply_cmd

  always_comb begin
    pins_in.sck   = sck;
    pins_in.wr_n  = wr_n;
    pins_in.rd_n  = rd_n;
    pins_in.dio   = dio_in;
    pins_in.txclk = tx_bit_clock_in;
    pins_in.txd   = tx_data_in;
    pins_in.demod = demod_in;
    pins_in.stat  = stat_in;
  end

  always_comb begin
    logic sck_rise;
    logic wr_fall;
    logic wr_rise;
    logic rd_fall;
    logic txclk_rise;
    logic int_clk;
    logic ext_clk;
    sck_rise   = 1'b0;
    wr_fall    = 1'b0;
    wr_rise    = 1'b0;
    rd_fall    = 1'b0;
    txclk_rise = 1'b0;
    int_clk    = 1'b0;
    ext_clk    = 1'b0;
    nxt_st     = st_ff;

    // Pins pass two stages; edges are found on the second stage only.
    nxt_st.sync1 = pins_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev  = st_ff.sync2;

    sck_rise   = st_ff.sync2.sck & ~st_ff.prev.sck;
    wr_fall    = ~st_ff.sync2.wr_n & st_ff.prev.wr_n;
    wr_rise    = st_ff.sync2.wr_n & ~st_ff.prev.wr_n;
    rd_fall    = ~st_ff.sync2.rd_n & st_ff.prev.rd_n;
    txclk_rise = st_ff.sync2.txclk & ~st_ff.prev.txclk;

    // A new write frame starts from an empty shift register.
    if (wr_fall) begin
      nxt_st.shift     = '0;
      nxt_st.shift_cnt = '0;
    end

    if (sck_rise && !st_ff.sync2.wr_n) begin
      if (st_ff.shift_cnt < CNT_W'(CMD_BITS)) begin
        nxt_st.shift[st_ff.shift_cnt] = st_ff.sync2.dio;
        nxt_st.shift_cnt              = st_ff.shift_cnt + CNT_W'(1);
      end
    end

    if (wr_rise) begin
      nxt_st.mode = apply_cmd(st_ff.mode, st_ff.shift);
    end

    nxt_st.dio_oe = ~st_ff.sync2.rd_n;
    if (rd_fall) begin
      nxt_st.stat_shift = st_ff.sync2.stat;
      nxt_st.dio_out    = st_ff.sync2.stat[ST_ENERGY];
    end else if (sck_rise && !st_ff.sync2.rd_n) begin
      nxt_st.stat_shift = {1'b0, st_ff.stat_shift[STAT_BITS-1:1]};
      nxt_st.dio_out    = st_ff.stat_shift[ST_FSK];
    end else if (st_ff.sync2.rd_n) begin
      nxt_st.dio_out = 1'b0;
    end

    int_clk = st_ff.mode.high_speed & st_ff.mode.sync_mode & ~st_ff.mode.ext_slave;
    ext_clk = st_ff.mode.high_speed & st_ff.mode.sync_mode & st_ff.mode.ext_slave;

    // The divider follows the terminal's clock phase in external mode.
    if (ext_clk && txclk_rise) begin
      nxt_st.div_cnt = '0;
      nxt_st.bit_clk = 1'b1;
    end else if (st_ff.div_cnt >= DIV_W'(BIT_HALF_CYC - 1)) begin
      nxt_st.div_cnt = '0;
      nxt_st.bit_clk = ~st_ff.bit_clk;
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + DIV_W'(1);
    end

    nxt_st.tx_clk_oe  = int_clk;
    nxt_st.tx_clk_out = int_clk & st_ff.bit_clk;
    nxt_st.rx_clk_out = ext_clk & st_ff.bit_clk;

    nxt_st.rx_data = st_ff.mode.force_mark | st_ff.sync2.demod;

    if (st_ff.mode.tx_space) begin
      nxt_st.tx_mark = 1'b0;
    end else if (st_ff.mode.dotting_pattern_send) begin
      nxt_st.tx_mark = st_ff.bit_clk;
    end else begin
      nxt_st.tx_mark = st_ff.sync2.txd;
    end

    nxt_st.ans_tone_act = st_ff.mode.answer_tone & ~st_ff.mode.high_speed;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_ff      <= '0;
      st_ff.mode <= MODE_DEFAULT;
      st_ff.sync1.sck  <= 1'b1;
      st_ff.sync2.sck  <= 1'b1;
      st_ff.prev.sck   <= 1'b1;
      st_ff.sync1.wr_n <= 1'b1;
      st_ff.sync2.wr_n <= 1'b1;
      st_ff.prev.wr_n  <= 1'b1;
      st_ff.sync1.rd_n <= 1'b1;
      st_ff.sync2.rd_n <= 1'b1;
      st_ff.prev.rd_n  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dio_out            = st_ff.dio_out;
  assign dio_oe             = st_ff.dio_oe;
  assign tx_mark            = st_ff.tx_mark;
  assign rx_data_out        = st_ff.rx_data;
  assign tx_bit_clock_out   = st_ff.tx_clk_out;
  assign tx_bit_clock_oe    = st_ff.tx_clk_oe;
  assign rx_bit_clock       = st_ff.rx_clk_out;
  assign mode_out           = st_ff.mode;
  assign answer_tone_active = st_ff.ans_tone_act;

endmodule : mscp_port

`default_nettype wire

// *** tb/mscp_port_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module mscp_port_props (
  // Clock, reset and strobes.
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  input wire logic                 wr_n,
  input wire logic                 rd_n,
  // Line and terminal data.
  input wire logic                 dio_oe,
  input wire logic                 tx_data_in,
  input wire logic                 tx_mark,
  input wire logic                 demod_in,
  input wire logic                 rx_data_out,
  // Bit clocks and modes.
  input wire logic                 tx_bit_clock_oe,
  input wire logic                 rx_bit_clock,
  input wire mscp_pkg::mscp_mode_t mode_out,
  input wire logic                 answer_tone_active
);
  import mscp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_hold;
    !wr_n [*6] |-> $stable(mode_out);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved while write held");
  property p_oe_on;
    !rd_n [*6] |-> dio_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("line not driven in read");
  property p_oe_off;
    rd_n [*6] |-> !dio_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("line driven outside read");
  property p_rx;
    ($stable(mode_out) && $stable(demod_in)) [*4] |->
      rx_data_out == (mode_out.force_mark || demod_in);
  endproperty
  a_rx: assert property (p_rx) else $error("receive data wrong");
  property p_tx;
    (!mode_out.dotting_pattern_send && $stable(mode_out) && $stable(tx_data_in)) [*4] |->
      tx_mark == (!mode_out.tx_space && tx_data_in);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit bit wrong");
  property p_ans;
    $stable(mode_out) [*2] |-> answer_tone_active == (mode_out.answer_tone && !mode_out.high_speed);
  endproperty
  a_ans: assert property (p_ans) else $error("answer tone gating wrong");
  property p_txclk;
    $stable(mode_out) [*3] |-> tx_bit_clock_oe ==
      (mode_out.high_speed && mode_out.sync_mode && !mode_out.ext_slave);
  endproperty
  a_txclk: assert property (p_txclk) else $error("transmit clock enable wrong");
  property p_rxclk;
    $stable(mode_out) [*3] |->
      !rx_bit_clock || (mode_out.high_speed && mode_out.sync_mode && mode_out.ext_slave);
  endproperty
  a_rxclk: assert property (p_rxclk) else $error("receive clock outside external mode");
  c_write: cover property (!wr_n ##1 wr_n);
  c_read: cover property (dio_oe [*8]);
  c_txclk: cover property ($rose(tx_bit_clock_oe));
endmodule : mscp_port_props

bind mscp_port mscp_port_props mscp_port_props_i (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .wr_n(wr_n), .rd_n(rd_n), .dio_oe(dio_oe),
  .tx_data_in(tx_data_in), .tx_mark(tx_mark), .demod_in(demod_in),
  .rx_data_out(rx_data_out), .tx_bit_clock_oe(tx_bit_clock_oe),
  .rx_bit_clock(rx_bit_clock), .mode_out(mode_out), .answer_tone_active(answer_tone_active)
);
`default_nettype wire

// *** tb/mscp_ctrl_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module mscp_ctrl_model (
  // Pacing clock.
  input  wire logic clk_sys,
  // Device side of the line.
  input  wire logic dio_out,
  input  wire logic dio_oe,
  // Controller strobes and line.
  output var  logic sck,
  output var  logic wr_n,
  output var  logic rd_n,
  output wire logic dio_in
);
  logic dv;
  initial begin
    sck  = 1'b1;
    wr_n = 1'b1;
    rd_n = 1'b1;
    dv   = 1'b0;
  end
  assign dio_in = dio_oe ? dio_out : dv;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // A full command frame carries all seven bits.
  task automatic send(input logic [6:0] c);
    send_n(c, 7);
  endtask : send
  // up to seven bits, LSB first
  task automatic send_n(input logic [6:0] c, input int n);
    wr_n <= 1'b0;
    tick(4);
    for (int i = 0; i < n; i++) begin
      dv  <= c[i];
      sck <= 1'b0;
      tick(4);
      sck <= 1'b1;
      tick(4);
    end
    wr_n <= 1'b1;
    dv   <= ~c[n-1];
    tick(8);
  endtask : send_n
  task automatic recv(output logic [3:0] s);
    rd_n <= 1'b0;
    tick(8);
    for (int i = 0; i < 4; i++) begin
      sck <= 1'b0;
      tick(4);
      s[i] = dio_in;
      sck <= 1'b1;
      tick(4);
    end
    rd_n <= 1'b1;
    tick(8);
  endtask : recv
endmodule : mscp_ctrl_model
`default_nettype wire

// *** tb/test_mscp_port.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_mscp_port;
  import mscp_pkg::*;
  logic       clk_sys = 1'b0;
  logic       sys_rst = 1'b1;
  logic       tx_data_in = 1'b0;
  logic       demod_in = 1'b0;
  logic       tx_bit_clock_in = 1'b0;
  logic [3:0] stat_in = 4'h0;
  logic       sck, wr_n, rd_n, dio_in, dio_out, dio_oe, tx_mark, rx_data_out;
  logic       tx_bit_clock_out, tx_bit_clock_oe, rx_bit_clock, answer_tone_active;
  mscp_mode_t mode_out, em;
  logic [6:0] c;
  logic [3:0] s;
  int         err_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         nt, nr;
  always #12.5 clk_sys = ~clk_sys;
  always #250 tx_bit_clock_in = ~tx_bit_clock_in;
  mscp_port #(.BIT_HALF_CYC(10)) mscp_port_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .sck(sck), .wr_n(wr_n), .rd_n(rd_n), .dio_in(dio_in), .dio_out(dio_out),
    .dio_oe(dio_oe), .tx_data_in(tx_data_in), .tx_mark(tx_mark), .demod_in(demod_in),
    .rx_data_out(rx_data_out), .tx_bit_clock_in(tx_bit_clock_in),
    .tx_bit_clock_out(tx_bit_clock_out), .tx_bit_clock_oe(tx_bit_clock_oe),
    .rx_bit_clock(rx_bit_clock), .stat_in(stat_in), .mode_out(mode_out),
    .answer_tone_active(answer_tone_active));
  mscp_ctrl_model mscp_ctrl_model_i (.clk_sys(clk_sys), .dio_out(dio_out),
    .dio_oe(dio_oe), .sck(sck), .wr_n(wr_n), .rd_n(rd_n), .dio_in(dio_in));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic count_rises(output int t, output int r);
    logic pt, pr;
    t = 0;
    r = 0;
    repeat (400) begin
      pt = tx_bit_clock_out;
      pr = rx_bit_clock;
      @(posedge clk_sys);
      t += int'(tx_bit_clock_out && !pt);
      r += int'(rx_bit_clock && !pr);
    end
  endtask : count_rises
  function automatic mscp_mode_t apply(input mscp_mode_t m, input logic [6:0] c);
    logic v;
    v = c[5];
    if (c[6]) begin
      case (c[3:0])
        4'hC: m.guard_550 = v;
        4'hD: m.guard_1800 = v;
        4'hE: m.row_off = v;
        4'hF: m.col_off = v;
        default: begin
          m.dial_digit = c[3:0];
          m.dial_on = v;
        end
      endcase
    end else begin
      case (c[4:0])
        5'h00: m = MODE_DEFAULT;
        5'h01: m.tone_on = v;
        5'h02: m.force_mark = v;
        5'h03: m.tx_level[0] = v;
        5'h04: m.tx_level[1] = v;
        5'h05: m.tx_on = v;
        5'h06: m.analog_loopback = v;
        5'h07: m.call_progress_monitor = v;
        5'h08: m.connect_indicator = v;
        5'h09: m.audio_level[0] = v;
        5'h0A: m.audio_level[1] = v;
        5'h0B: m.frame_length[0] = v;
        5'h0C: m.frame_length[1] = v;
        5'h0D: m.sync_mode = v;
        5'h0E: m.high_speed = v;
        5'h0F: m.answer_mode = v;
        5'h10: m.tx_space = v;
        5'h11: m.scrambler_off = v;
        5'h12: m.digital_loopback = v;
        5'h13: m.dotting_pattern_send = v;
        5'h14: m.locked_internal = v;
        5'h15: m.ext_slave = v;
        5'h17: m.answer_tone = v;
        default: ;
      endcase
    end
    return m;
  endfunction : apply
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(9164));
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    em = MODE_DEFAULT;
    chk("mode", 32'(em), 32'(mode_out));
    for (int i = 0; i < 256; i++) begin
      c = (i < 128) ? 7'(i) : 7'($urandom);
      stat_in <= 4'($urandom);
      demod_in <= 1'($urandom);
      tx_data_in <= 1'($urandom);
      mscp_ctrl_model_i.send(c);
      em = apply(em, c);
      chk("mode", 32'(em), 32'(mode_out));
      chk("rx_data", 32'(em.force_mark | demod_in), 32'(rx_data_out));
      chk("ans_tone", 32'(em.answer_tone & !em.high_speed), 32'(answer_tone_active));
      chk("tx_clk_oe", 32'(em.high_speed & em.sync_mode & !em.ext_slave),
          32'(tx_bit_clock_oe));
      if (!em.dotting_pattern_send) begin
        chk("tx_mark", 32'(!em.tx_space & tx_data_in), 32'(tx_mark));
      end
      mscp_ctrl_model_i.recv(s);
      chk("status", 32'(stat_in), 32'(s));
    end
    // A short frame must not reuse the top bit left over from the frame before.
    mscp_ctrl_model_i.send(7'h7F);
    em = apply(em, 7'h7F);
    mscp_ctrl_model_i.send_n(7'h6D, 6);
    em = apply(em, 7'h6D & 7'h3F);
    chk("short_mode", 32'(em), 32'(mode_out));
    mscp_ctrl_model_i.send(7'h00);
    mscp_ctrl_model_i.send(7'h2D);
    mscp_ctrl_model_i.send(7'h2E);
    count_rises(nt, nr);
    chk("tx_clk_rises", 32'd20, 32'(nt));
    mscp_ctrl_model_i.send(7'h35);
    repeat (40) @(posedge clk_sys);
    count_rises(nt, nr);
    chk("rx_clk_rises", 32'd20, 32'(nr));
    print_verdict();
  end
endmodule : test_mscp_port
`default_nettype wire
